// File: bench/serial_peer.sv
`timescale 1ns/1ns

module serial_peer #(
	parameter int BIT_CYC = 16
) (
	// Line side
	input wire logic i_clk,
	input wire logic i_txd,
	input wire logic i_par_en,
	output logic o_rxd
);
	logic [8:0] got[$];
	logic [8:0] sh;

	initial o_rxd = 1'b1;

	// Start, data LSB first, optional parity, stop; line idles high after
	task automatic send(input logic [7:0] d, input logic pb, input logic st);
		logic [10:0] f;
		f = i_par_en ? {st, pb, d, 1'b0} : {1'b1, st, d, 1'b0};
		for (int i = 0; i < (i_par_en ? 11 : 10); i++)
		begin
			o_rxd = f[i];
			repeat (BIT_CYC) @(posedge i_clk);
			#1;
		end
		o_rxd = 1'b1;
	endtask : send

	// Samples mid-bit; stop level kept in the top bit so a bad stop shows up
	always
	begin
		@(negedge i_txd);
		repeat (BIT_CYC / 2) @(posedge i_clk);
		for (int i = 0; i < 9; i++)
		begin
			if (i == 8 && i_par_en)
				repeat (BIT_CYC) @(posedge i_clk);
			repeat (BIT_CYC) @(posedge i_clk);
			sh[i] = i_txd;
		end
		got.push_back(sh);
	end

	// Bounded wait: a frame that never comes returns zero and fails the compare
	task automatic get(output logic [8:0] v);
		int t;
		t = 0;
		while (got.size() == 0 && t < 24 * BIT_CYC)
		begin
			@(posedge i_clk);
			#1;
			t++;
		end
		v = (got.size() != 0) ? got.pop_front() : 9'h000;
	endtask : get
endmodule : serial_peer

// File: bench/tb_top.sv
`timescale 1ns/1ns

module tb_top;
	// Clocks per bit: mode 2 A=3, mode 1 B=8 A=1, mode 0 A=1
	localparam int CYC [3] = '{3 + 2, (8 + 1) * (1 + 2), 16 * (1 + 2)};

	logic i_clk;
	logic i_nrst;
	logic [2:0][31:0] i_baud_divider_reg;
	logic [2:0] i_par_en, i_par_even, i_auto_flow_en, i_lin_en, i_tx_valid, i_rx_ready, i_cts_n;
	logic [2:0][3:0] i_rts_trigger_level;
	logic [2:0][6:0] i_rx_trigger_level, i_rx_timeout, i_irq_en, i_irq_clear;
	logic [2:0][7:0] i_tx_data, o_rx_data;
	wire [2:0] i_rxd;
	logic [2:0] o_tx_ready, o_rx_valid, o_txd, o_rts_n, o_tx_busy, o_rx_busy;
	logic [2:0][2:0] o_rx_err;
	logic [2:0][6:0] o_irq_status, o_rx_count;
	logic [2:0][3:0] o_err_status;
	logic o_irq_shared, o_irq_own;
	logic [7:0] txq[3][$];
	logic [10:0] rxq[3][$];
	logic [8:0] v;
	int bad_count, cmp_count, cyc, n, t;
	int seed = 32'h0bf6_56dc;

	uart_baud_and_interrupt_core dut (
		.i_clk, .i_nrst, .i_baud_divider_reg, .i_par_en, .i_par_even, .i_auto_flow_en,
		.i_lin_en, .i_rts_trigger_level, .i_rx_trigger_level, .i_rx_timeout, .i_irq_en,
		.i_irq_clear, .i_tx_valid, .i_tx_data, .o_tx_ready, .o_rx_valid, .o_rx_data,
		.o_rx_err, .i_rx_ready, .i_rxd, .o_txd, .i_cts_n, .o_rts_n, .o_irq_status,
		.o_err_status, .o_tx_busy, .o_rx_busy, .o_rx_count, .o_irq_shared, .o_irq_own
	);
	serial_peer #(.BIT_CYC(CYC[0])) p0 (.i_clk, .i_txd(o_txd[0]), .i_par_en(i_par_en[0]),
		.o_rxd(i_rxd[0]));
	serial_peer #(.BIT_CYC(CYC[1])) p1 (.i_clk, .i_txd(o_txd[1]), .i_par_en(i_par_en[1]),
		.o_rxd(i_rxd[1]));
	serial_peer #(.BIT_CYC(CYC[2])) p2 (.i_clk, .i_txd(o_txd[2]), .i_par_en(i_par_en[2]),
		.o_rxd(i_rxd[2]));

	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			bad_count++;
			complete_run();
		end
	end

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	task automatic step(input int k);
		repeat (k) @(posedge i_clk);
		#1;
	endtask : step

	task automatic chk_word(input logic [10:0] got, input logic [10:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_word

	// Wide enough for the widest status concatenation, so no bit is cut off
	task automatic chk_flag(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_flag

	task automatic push(input int ch, input int k);
		n = 0;
		repeat (k)
		begin
			i_tx_valid[ch] = 1'b1;
			i_tx_data[ch] = 8'($random(seed));
			if (o_tx_ready[ch] === 1'b1)
			begin
				txq[ch].push_back(i_tx_data[ch]);
				n++;
			end
			step(1);
		end
		i_tx_valid[ch] = 1'b0;
	endtask : push

	task automatic drain(input int ch, input int k);
		repeat (k)
		begin
			case (ch)
				0: p0.get(v);
				1: p1.get(v);
				default: p2.get(v);
			endcase
			chk_word({2'b00, v}, {3'b001, txq[ch].pop_front()});
		end
	endtask : drain

	task automatic rx(input int ch, input logic [7:0] d, input logic pb, input logic st,
		input logic [2:0] e);
		rxq[ch].push_back({e, d});
		// Three bits into the frame the receiver must report a transfer in progress
		fork
			begin
				step(CYC[ch] * 3);
				chk_flag(o_rx_busy[ch], 1'b1);
			end
		join_none
		case (ch)
			0: p0.send(d, pb, st);
			1: p1.send(d, pb, st);
			default: p2.send(d, pb, st);
		endcase
		step(2);
	endtask : rx

	task automatic pop(input int ch);
		t = 0;
		while (o_rx_valid[ch] !== 1'b1 && t < 100)
		begin
			step(1);
			t++;
		end
		chk_word({o_rx_err[ch], o_rx_data[ch]}, rxq[ch].pop_front());
		i_rx_ready[ch] = 1'b1;
		step(1);
		i_rx_ready[ch] = 1'b0;
		step(1);
	endtask : pop

	initial
	begin
		i_nrst = 1'b0;
		// Extension stays off except in mode 1, where it is 8; mode 2 divisor is 3
		i_baud_divider_reg[0] = 32'h3000_0003;
		i_baud_divider_reg[1] = 32'h2800_0001;
		i_baud_divider_reg[2] = 32'h0000_0001;
		i_par_en = 3'h1;
		i_par_even = 3'h1;
		i_auto_flow_en = 3'h0;
		i_lin_en = 3'h4;
		i_rts_trigger_level = {4'h0, 4'h0, 4'h2};
		i_rx_trigger_level = {7'h01, 7'h04, 7'h01};
		i_rx_timeout = {7'h04, 7'h7f, 7'h7f};
		i_irq_en = '0;
		i_irq_clear = '0;
		i_tx_valid = '0;
		i_tx_data = '0;
		i_rx_ready = '0;
		i_cts_n = '0;
		step(5);
		chk_flag({o_txd, o_rts_n, o_tx_ready, o_rx_valid}, 12'hff8);
		chk_flag({o_irq_status[2][0], o_irq_status[1][0], o_irq_status[0][0]}, 3'h7);
		step(5);
		i_nrst = 1'b1;
		step(2);
		chk_flag(o_rts_n, 3'h4);
		for (int k = 0; k < 3; k++)
		begin
			i_irq_en = 21'h1 << (7 * k);
			step(1);
			chk_flag({o_irq_shared, o_irq_own}, (k == 1) ? 2'h1 : 2'h2);
		end
		i_irq_en = '0;
		for (int k = 0; k < 3; k++)
		begin
			push(k, 3);
			drain(k, 3);
		end
		for (int k = 0; k < 3; k++)
			repeat (2)
			begin
				v[7:0] = 8'($random(seed));
				rx(k, v[7:0], ^v[7:0], 1'b1, 3'h0);
				pop(k);
			end
		// Parity error, framing error, then break with the extra flag enabled
		rx(0, 8'hc3, 1'b1, 1'b1, 3'h1);
		rx(1, 8'h5a, 1'b0, 1'b0, 3'h2);
		rx(2, 8'h00, 1'b0, 1'b0, 3'h6);
		chk_flag({o_err_status[2][2:0], o_err_status[1][2:0], o_err_status[0][2:0]}, 9'h191);
		chk_flag({o_irq_status[2][6], o_irq_status[2][2], o_irq_status[1][2],
			o_irq_status[0][2]}, 4'hf);
		i_irq_clear = {3{7'h44}};
		step(1);
		i_irq_clear = '0;
		step(1);
		chk_flag({o_err_status[2][2:0], o_err_status[1][2:0], o_err_status[0][2:0]}, 9'h000);
		chk_flag({o_irq_status[2][6], o_irq_status[2][2], o_irq_status[1][2],
			o_irq_status[0][2]}, 4'h0);
		for (int k = 0; k < 3; k++)
			pop(k);
		// Line clear held through a break frame: the set wins at the stop, the clear after
		i_irq_clear[2][2] = 1'b1;
		rx(2, 8'h00, 1'b0, 1'b0, 3'h6);
		i_irq_clear[2][2] = 1'b0;
		step(1);
		chk_flag({o_irq_status[2][6], o_err_status[2]}, 5'h10);
		pop(2);
		i_auto_flow_en = 3'h1;
		step(2);
		chk_flag(o_rts_n[0], 1'b0);
		i_cts_n[0] = 1'b1;
		step(2);
		chk_flag(o_irq_status[0][4], 1'b1);
		push(0, 65);
		chk_flag(11'(n), 11'h040);
		step(CYC[0] * 12);
		chk_flag({o_txd[0], o_tx_busy[0], o_err_status[0][3], o_irq_status[0][5]}, 4'hb);
		i_cts_n[0] = 1'b0;
		drain(0, 64);
		rx(0, 8'h11, 1'b0, 1'b1, 3'h0);
		rx(0, 8'h22, 1'b0, 1'b1, 3'h0);
		step(2);
		chk_flag(o_rts_n[0], 1'b1);
		pop(0);
		step(2);
		chk_flag(o_rts_n[0], 1'b0);
		pop(0);
		// Seventeenth byte finds the receive buffer full and is lost
		for (int i = 0; i < 17; i++)
		begin
			rx(1, 8'($random(seed)), 1'b0, 1'b1, 3'h0);
			chk_flag(o_irq_status[1][1], 11'(i >= 3));
		end
		void'(rxq[1].pop_back());
		chk_flag({o_rx_count[1], o_err_status[1][3]}, {7'h10, 1'b1});
		repeat (16) pop(1);
		rx(2, 8'h3c, 1'b0, 1'b1, 3'h0);
		t = 0;
		while (o_irq_status[2][3] !== 1'b1 && t < 200)
		begin
			step(1);
			t++;
		end
		chk_flag(o_irq_status[2][3], 1'b1);
		pop(2);
		complete_run();
	end
endmodule : tb_top

// File: logic/uart_baud_and_interrupt_core.sv
`timescale 1ns/1ns

module uart_fifo #(
	parameter int WIDTH = uart_core_pkg::DATA_W,
	parameter int DEPTH = uart_core_pkg::BUF_DEFAULT_DEPTH
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Fill side
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	// Drain side
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready,
	output logic [$clog2(DEPTH+1)-1:0] o_count
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH+1);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [CW-1:0] cnt;
	} fifo_s;
	fifo_s st_ff;
	fifo_s nxt_st;
	logic push;
	logic pop;

	// Depth need not be a power of two, so pointers wrap explicitly
	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		return (p == AW'(DEPTH-1)) ? '0 : AW'(p + 1'b1);
	endfunction : ptr_inc

	assign o_in_ready = (st_ff.cnt != CW'(DEPTH));
	assign o_out_valid = (st_ff.cnt != '0);
	assign o_out_data = st_ff.mem[st_ff.rp];
	assign o_count = st_ff.cnt;

	always_comb
	begin
		nxt_st = st_ff;
		push = i_in_valid && o_in_ready;
		pop = i_out_ready && o_out_valid;
		if (push)
		begin
			nxt_st.mem[st_ff.wp] = i_in_data;
			nxt_st.wp = ptr_inc(st_ff.wp);
		end
		if (pop)
			nxt_st.rp = ptr_inc(st_ff.rp);
		if (push && !pop)
			nxt_st.cnt = CW'(st_ff.cnt + 1'b1);
		else if (pop && !push)
			nxt_st.cnt = CW'(st_ff.cnt - 1'b1);
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	AST_FIFO_FULL_HOLDS: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(!o_in_ready && i_in_valid && !i_out_ready) |=> (o_count == CW'(DEPTH)))
		else $error("fifo count moved while full and stalled");
	AST_FIFO_PUSH_COUNT: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(push && !pop) |=> (o_count == $past(o_count) + 1'b1))
		else $error("fifo count did not rise on push");
	COV_FIFO_FULL: cover property (@(posedge i_clk) disable iff (!i_nrst) !o_in_ready);

endmodule : uart_fifo

module uart_channel #(
	parameter int FIFO_DEPTH = uart_core_pkg::NS_FIFO_DEPTH,
	parameter bit HAS_FLOW = 1'b1
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Configuration
	input wire logic [31:0] i_baud_divider_reg,
	input wire logic i_par_en,
	input wire logic i_par_even,
	input wire logic i_auto_flow_en,
	input wire logic i_lin_en,
	input wire logic [3:0] i_rts_trigger_level,
	input wire logic [6:0] i_rx_trigger_level,
	input wire logic [6:0] i_rx_timeout,
	input wire logic [6:0] i_irq_en,
	input wire logic [6:0] i_irq_clear,
	// Transmit words from the CPU
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_data,
	output logic o_tx_ready,
	// Received words to the CPU
	output logic o_rx_valid,
	output logic [7:0] o_rx_data,
	output logic [2:0] o_rx_err,
	input wire logic i_rx_ready,
	// Serial line
	input wire logic i_rxd,
	output logic o_txd,
	input wire logic i_cts_n,
	output logic o_rts_n,
	// Status
	output logic [6:0] o_irq_status,
	output logic [3:0] o_err_status,
	output logic o_tx_busy,
	output logic o_rx_busy,
	output logic [6:0] o_rx_count,
	output logic o_irq
);
	localparam int CW = $clog2(FIFO_DEPTH+1);
	typedef enum logic {T_IDLE, T_SHIFT} tx_e;
	typedef enum logic [1:0] {R_IDLE, R_START, R_SHIFT} rx_e;
	typedef struct packed {
		logic [16:0] pre;
		tx_e tx_st;
		logic [4:0] tx_os;
		logic [3:0] tx_left;
		logic [9:0] tx_sh;
		logic txd;
		rx_e rx_st;
		logic [4:0] rx_os;
		logic [3:0] rx_left;
		logic [9:0] rx_sh;
		logic [6:0] tout;
		logic cts_prev;
		logic [3:0] err;
		logic modem;
		logic lin;
		logic rts_n;
	} chan_s;
	chan_s st_ff;
	chan_s nxt_st;

	logic tick;
	logic [4:0] os_len;
	logic tx_start;
	logic tx_bit_end;
	logic tx_f_valid;
	logic [7:0] tx_f_data;
	logic [CW-1:0] tx_f_count;
	logic rx_done;
	logic rx_push_ready;
	logic [10:0] rx_entry;
	logic [CW-1:0] rx_f_count;
	logic [9:0] nsh;
	logic [7:0] rdata;
	logic pe;
	logic fe;
	logic brk;
	logic par_calc;

	// Ticks per bit: mode 2 one, mode 1 ext+1, mode 0 sixteen
	function automatic logic [4:0] bit_ticks(input logic [31:0] r);
		if (r[uart_core_pkg::DIV_EXT_EN_BIT] && r[uart_core_pkg::DIV_ONE_BIT])
			return uart_core_pkg::OVERSAMPLE_ONE;
		else if (r[uart_core_pkg::DIV_EXT_EN_BIT])
			return 5'({1'b0, r[uart_core_pkg::DIV_EXT_MSB:uart_core_pkg::DIV_EXT_LSB]}) + 5'h01;
		else
			return uart_core_pkg::OVERSAMPLE_NORMAL;
	endfunction : bit_ticks

	function automatic logic parity_of(input logic [7:0] d, input logic even);
		return even ? ^d : ~^d;
	endfunction : parity_of

	uart_fifo #(.WIDTH(uart_core_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_in_valid(i_tx_valid),
		.i_in_data(i_tx_data),
		.o_in_ready(o_tx_ready),
		.o_out_valid(tx_f_valid),
		.o_out_data(tx_f_data),
		.i_out_ready(tx_start),
		.o_count(tx_f_count)
	);

	// Each entry carries three error bits beside the byte
	uart_fifo #(.WIDTH(uart_core_pkg::RX_ENTRY_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_in_valid(rx_done),
		.i_in_data(rx_entry),
		.o_in_ready(rx_push_ready),
		.o_out_valid(o_rx_valid),
		.o_out_data({o_rx_err, o_rx_data}),
		.i_out_ready(i_rx_ready),
		.o_count(rx_f_count)
	);

	// Divisor width caps the prescaler; a divisor of all ones still wraps
	assign tick = (st_ff.pre == 17'({1'b0, i_baud_divider_reg[uart_core_pkg::DIVISOR_W-1:0]}) + 17'h1);
	assign os_len = bit_ticks(i_baud_divider_reg);
	assign tx_bit_end = tick && (st_ff.tx_st == T_SHIFT) && (st_ff.tx_os == os_len - 5'h01);
	// CTS is only honoured on flow-capable channels
	assign tx_start = tick && (st_ff.tx_st == T_IDLE) && tx_f_valid
		&& (!HAS_FLOW || !i_auto_flow_en || !i_cts_n);
	assign o_txd = st_ff.txd;
	assign o_rts_n = st_ff.rts_n;
	assign o_tx_busy = (st_ff.tx_st == T_SHIFT);
	assign o_rx_busy = (st_ff.rx_st != R_IDLE);
	assign o_rx_count = 7'(rx_f_count);
	assign o_err_status = st_ff.err;
	assign o_irq_status[uart_core_pkg::IRQ_TX_EMPTY] = (tx_f_count == '0);
	assign o_irq_status[uart_core_pkg::IRQ_RX_THR] = (rx_f_count != '0)
		&& (7'(rx_f_count) >= i_rx_trigger_level);
	assign o_irq_status[uart_core_pkg::IRQ_LINE] = |st_ff.err[uart_core_pkg::ERR_BRK:0];
	assign o_irq_status[uart_core_pkg::IRQ_TOUT] = (rx_f_count != '0) && (st_ff.tout >= i_rx_timeout);
	assign o_irq_status[uart_core_pkg::IRQ_MODEM] = st_ff.modem;
	assign o_irq_status[uart_core_pkg::IRQ_BUF] = st_ff.err[uart_core_pkg::ERR_BUF];
	assign o_irq_status[uart_core_pkg::IRQ_LIN_BRK] = st_ff.lin;
	assign o_irq = |(o_irq_status & i_irq_en);
	assign rx_entry = {brk, fe, pe, rdata};

	always_comb
	begin
		nxt_st = st_ff;
		rx_done = 1'b0;
		nsh = {i_rxd, st_ff.rx_sh[9:1]};
		rdata = i_par_en ? nsh[7:0] : nsh[8:1];
		par_calc = parity_of(rdata, i_par_even);
		pe = i_par_en && (nsh[8] != par_calc);
		fe = !nsh[9];
		brk = ~|nsh;
		nxt_st.pre = tick ? 17'h0 : 17'(st_ff.pre + 17'h1);
		// Transmitter
		unique case (st_ff.tx_st)
			T_IDLE:
			begin
				if (tx_start)
				begin
					nxt_st.tx_st = T_SHIFT;
					nxt_st.tx_os = 5'h00;
					nxt_st.txd = 1'b0;
					nxt_st.tx_sh = {1'b1, i_par_en ? parity_of(tx_f_data, i_par_even) : 1'b1, tx_f_data};
					nxt_st.tx_left = i_par_en ? uart_core_pkg::BITS_AFTER_START_PAR
						: uart_core_pkg::BITS_AFTER_START_NOPAR;
				end
			end
			T_SHIFT:
			begin
				if (tx_bit_end)
				begin
					nxt_st.tx_os = 5'h00;
					if (st_ff.tx_left == 4'h0)
					begin
						nxt_st.tx_st = T_IDLE;
						nxt_st.txd = uart_core_pkg::TXD_IDLE;
					end
					else
					begin
						nxt_st.txd = st_ff.tx_sh[0];
						nxt_st.tx_sh = {1'b1, st_ff.tx_sh[9:1]};
						nxt_st.tx_left = 4'(st_ff.tx_left - 4'h1);
					end
				end
				else if (tick)
					nxt_st.tx_os = 5'(st_ff.tx_os + 5'h01);
			end
		endcase
		// Receiver: check start at mid-bit unless a bit is one tick (mode 2), then sample once per bit
		unique case (st_ff.rx_st)
			R_IDLE:
			begin
				if (tick && !i_rxd)
				begin
					nxt_st.rx_sh = 10'h000;
					nxt_st.rx_os = 5'h01;
					nxt_st.rx_left = i_par_en ? uart_core_pkg::BITS_AFTER_START_PAR
						: uart_core_pkg::BITS_AFTER_START_NOPAR;
					nxt_st.rx_st = ((os_len >> 1) == 5'h00) ? R_SHIFT : R_START;
					if ((os_len >> 1) == 5'h00)
						nxt_st.rx_os = 5'h00;
				end
			end
			R_START:
			begin
				if (tick && (st_ff.rx_os >= (os_len >> 1)))
				begin
					nxt_st.rx_os = 5'h00;
					nxt_st.rx_st = i_rxd ? R_IDLE : R_SHIFT;
				end
				else if (tick)
					nxt_st.rx_os = 5'(st_ff.rx_os + 5'h01);
			end
			R_SHIFT:
			begin
				if (tick && (st_ff.rx_os == os_len - 5'h01))
				begin
					nxt_st.rx_os = 5'h00;
					nxt_st.rx_sh = nsh;
					nxt_st.rx_left = 4'(st_ff.rx_left - 4'h1);
					if (st_ff.rx_left == 4'h1)
					begin
						rx_done = 1'b1;
						nxt_st.rx_st = R_IDLE;
					end
				end
				else if (tick)
					nxt_st.rx_os = 5'(st_ff.rx_os + 5'h01);
			end
			default:
				nxt_st.rx_st = R_IDLE;
		endcase
		// Idle timer restarts on any receive activity or a read
		if (rx_done || (st_ff.rx_st != R_IDLE) || (o_rx_valid && i_rx_ready))
			nxt_st.tout = 7'h00;
		else if (tick && (rx_f_count != '0) && (st_ff.tout != uart_core_pkg::TOUT_MAX))
			nxt_st.tout = 7'(st_ff.tout + 7'h01);
		// Sticky flags: a set in the clearing cycle wins
		nxt_st.err[uart_core_pkg::ERR_BRK:0] = (st_ff.err[uart_core_pkg::ERR_BRK:0]
			& {3{~i_irq_clear[uart_core_pkg::IRQ_LINE]}})
			| ({3{rx_done}} & {brk, fe, pe});
		nxt_st.err[uart_core_pkg::ERR_BUF] = (st_ff.err[uart_core_pkg::ERR_BUF]
			&& !i_irq_clear[uart_core_pkg::IRQ_BUF])
			|| (rx_done && !rx_push_ready) || (i_tx_valid && !o_tx_ready);
		nxt_st.cts_prev = i_cts_n;
		nxt_st.modem = (st_ff.modem && !i_irq_clear[uart_core_pkg::IRQ_MODEM])
			|| (HAS_FLOW && (st_ff.cts_prev != i_cts_n));
		nxt_st.lin = (st_ff.lin && !i_irq_clear[uart_core_pkg::IRQ_LIN_BRK])
			|| (i_lin_en && rx_done && brk);
		if (HAS_FLOW && i_auto_flow_en)
			nxt_st.rts_n = (7'(rx_f_count) >= {3'h0, i_rts_trigger_level});
		else
			nxt_st.rts_n = !HAS_FLOW;
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			st_ff <= '0;
			st_ff.txd <= uart_core_pkg::TXD_IDLE;
			st_ff.rts_n <= uart_core_pkg::RTS_N_RESET;
			st_ff.cts_prev <= 1'b1;
		end
		else
			st_ff <= nxt_st;
	end

	// Bit length checks; they assume the divider is steady during a frame
	int unsigned tick_gap;
	int unsigned bit_cyc;
	int unsigned div_p2;
	assign div_p2 = 32'(i_baud_divider_reg[uart_core_pkg::DIVISOR_W-1:0]) + 2;
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			// Prescaler restarts at zero, so the first period is already a full one
			tick_gap <= 1;
			bit_cyc <= 0;
		end
		else
		begin
			tick_gap <= tick ? 1 : tick_gap + 1;
			bit_cyc <= (tx_start || tx_bit_end) ? 1 : bit_cyc + 1;
		end
	end

	AST_TICK_PERIOD: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(tick && $stable(i_baud_divider_reg)) |-> (tick_gap == div_p2))
		else $error("bit clock period is not divisor plus two");
	AST_MODE0_BIT: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(tx_bit_end && !i_baud_divider_reg[uart_core_pkg::DIV_EXT_EN_BIT]) |-> (bit_cyc == 16 * div_p2))
		else $error("mode 0 bit length wrong");
	AST_MODE1_BIT: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(tx_bit_end && i_baud_divider_reg[uart_core_pkg::DIV_EXT_EN_BIT]
		&& !i_baud_divider_reg[uart_core_pkg::DIV_ONE_BIT])
		|-> (bit_cyc == (32'(i_baud_divider_reg[27:24]) + 1) * div_p2))
		else $error("mode 1 bit length wrong");
	AST_MODE2_BIT: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(tx_bit_end && i_baud_divider_reg[uart_core_pkg::DIV_EXT_EN_BIT]
		&& i_baud_divider_reg[uart_core_pkg::DIV_ONE_BIT]) |-> (bit_cyc == div_p2))
		else $error("mode 2 bit length wrong");
	AST_RTS_AT_TRIGGER: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(HAS_FLOW && i_auto_flow_en && (7'(rx_f_count) >= {3'h0, i_rts_trigger_level})) |=> o_rts_n)
		else $error("RTS still asserted at trigger level");
	AST_TX_WAITS_CTS: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(HAS_FLOW && i_auto_flow_en && i_cts_n && !o_tx_busy) |=> (!o_tx_busy && o_txd))
		else $error("transmit started without CTS");
	AST_LINE_ERR_SET: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(rx_done && (fe || pe)) |=> o_irq_status[uart_core_pkg::IRQ_LINE])
		else $error("line status flag missed an error");
	AST_SET_WINS: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(rx_done && brk && i_irq_clear[uart_core_pkg::IRQ_LINE])
		|=> o_err_status[uart_core_pkg::ERR_BRK])
		else $error("break lost to a same-cycle clear");
	COV_TX_FRAME: cover property (@(posedge i_clk) disable iff (!i_nrst) tx_bit_end && st_ff.tx_left == 4'h0);
	COV_RX_BYTE: cover property (@(posedge i_clk) disable iff (!i_nrst) rx_done && rx_push_ready);
	COV_RTS_DROP: cover property (@(posedge i_clk) disable iff (!i_nrst) $rose(o_rts_n));

endmodule : uart_channel

// What this block does
// - Three channels; channels 0,1 have flow control
// - Serial-to-parallel receive, parallel-to-serial transmit
// - Seven interrupt kinds per channel
// - Channels 0,2 share line 12; 1 owns 13
// - Channel 0 has 64-byte TX and RX FIFOs
// - Channels 1,2 have 16-byte TX and RX FIFOs
// - Status readable anytime with four error flags
// - Divider makes bit clock from divisor plus two
// - Mode 0: clock over sixteen times divisor+2
// - Mode 1: clock over (ext+1)(divisor+2), ext>=8
// - Mode 2: clock over divisor+2, divisor>=3
// - Auto flow: RTS drops at trigger, TX needs CTS
module uart_baud_and_interrupt_core (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Per-channel configuration
	input wire logic [2:0][31:0] i_baud_divider_reg,
	input wire logic [2:0] i_par_en,
	input wire logic [2:0] i_par_even,
	input wire logic [2:0] i_auto_flow_en,
	input wire logic [2:0] i_lin_en,
	input wire logic [2:0][3:0] i_rts_trigger_level,
	input wire logic [2:0][6:0] i_rx_trigger_level,
	input wire logic [2:0][6:0] i_rx_timeout,
	input wire logic [2:0][6:0] i_irq_en,
	input wire logic [2:0][6:0] i_irq_clear,
	// Transmit words
	input wire logic [2:0] i_tx_valid,
	input wire logic [2:0][7:0] i_tx_data,
	output logic [2:0] o_tx_ready,
	// Received words
	output logic [2:0] o_rx_valid,
	output logic [2:0][7:0] o_rx_data,
	output logic [2:0][2:0] o_rx_err,
	input wire logic [2:0] i_rx_ready,
	// Serial lines
	input wire logic [2:0] i_rxd,
	output logic [2:0] o_txd,
	input wire logic [2:0] i_cts_n,
	output logic [2:0] o_rts_n,
	// Status and interrupt lines
	output logic [2:0][6:0] o_irq_status,
	output logic [2:0][3:0] o_err_status,
	output logic [2:0] o_tx_busy,
	output logic [2:0] o_rx_busy,
	output logic [2:0][6:0] o_rx_count,
	output logic o_irq_shared,
	output logic o_irq_own
);
	logic [2:0] ch_irq;

	for (genvar g = 0; g < uart_core_pkg::CH_NUM; g++)
	begin : g_ch
		uart_channel #(
			.FIFO_DEPTH((g == 0) ? uart_core_pkg::HS_FIFO_DEPTH : uart_core_pkg::NS_FIFO_DEPTH),
			.HAS_FLOW(g < uart_core_pkg::FLOW_CH_NUM)
		) u_ch (
			.i_clk(i_clk),
			.i_nrst(i_nrst),
			.i_baud_divider_reg(i_baud_divider_reg[g]),
			.i_par_en(i_par_en[g]),
			.i_par_even(i_par_even[g]),
			.i_auto_flow_en(i_auto_flow_en[g]),
			.i_lin_en(i_lin_en[g]),
			.i_rts_trigger_level(i_rts_trigger_level[g]),
			.i_rx_trigger_level(i_rx_trigger_level[g]),
			.i_rx_timeout(i_rx_timeout[g]),
			.i_irq_en(i_irq_en[g]),
			.i_irq_clear(i_irq_clear[g]),
			.i_tx_valid(i_tx_valid[g]),
			.i_tx_data(i_tx_data[g]),
			.o_tx_ready(o_tx_ready[g]),
			.o_rx_valid(o_rx_valid[g]),
			.o_rx_data(o_rx_data[g]),
			.o_rx_err(o_rx_err[g]),
			.i_rx_ready(i_rx_ready[g]),
			.i_rxd(i_rxd[g]),
			.o_txd(o_txd[g]),
			.i_cts_n(i_cts_n[g]),
			.o_rts_n(o_rts_n[g]),
			.o_irq_status(o_irq_status[g]),
			.o_err_status(o_err_status[g]),
			.o_tx_busy(o_tx_busy[g]),
			.o_rx_busy(o_rx_busy[g]),
			.o_rx_count(o_rx_count[g]),
			.o_irq(ch_irq[g])
		);
	end

	// Line 12 is shared by channels 0 and 2, line 13 is channel 1 alone
	assign o_irq_shared = ch_irq[0] | ch_irq[2];
	assign o_irq_own = ch_irq[1];

endmodule : uart_baud_and_interrupt_core

// File: pkg/uart_core_pkg.sv
package uart_core_pkg;

	// Channel layout
	localparam int CH_NUM = 3;
	localparam int HS_FIFO_DEPTH = 64;
	localparam int NS_FIFO_DEPTH = 16;
	localparam int FLOW_CH_NUM = 2;
	localparam int BUF_DEFAULT_DEPTH = 8;

	// Divider register fields
	localparam int DIV_EXT_EN_BIT = 29;
	localparam int DIV_ONE_BIT = 28;
	localparam int DIV_EXT_MSB = 27;
	localparam int DIV_EXT_LSB = 24;
	localparam int DIVISOR_W = 16;
	localparam logic [4:0] OVERSAMPLE_NORMAL = 5'h10;
	localparam logic [4:0] OVERSAMPLE_ONE = 5'h01;

	// Interrupt status bit positions
	localparam int IRQ_W = 7;
	localparam int IRQ_TX_EMPTY = 0;
	localparam int IRQ_RX_THR = 1;
	localparam int IRQ_LINE = 2;
	localparam int IRQ_TOUT = 3;
	localparam int IRQ_MODEM = 4;
	localparam int IRQ_BUF = 5;
	localparam int IRQ_LIN_BRK = 6;

	// Error status bit positions
	localparam int ERR_W = 4;
	localparam int ERR_PAR = 0;
	localparam int ERR_FRM = 1;
	localparam int ERR_BRK = 2;
	localparam int ERR_BUF = 3;

	// Frame shape: data bits, bits after start with and without parity
	localparam int DATA_W = 8;
	localparam int RX_ENTRY_W = 11;
	localparam logic [3:0] BITS_AFTER_START_NOPAR = 4'h9;
	localparam logic [3:0] BITS_AFTER_START_PAR = 4'ha;
	localparam logic [6:0] TOUT_MAX = 7'h7f;

	// Reset levels
	localparam logic TXD_IDLE = 1'b1;
	localparam logic RTS_N_RESET = 1'b1;

endpackage : uart_core_pkg
